// >>> flash_protect_ctrl.sv
// Code flash protection unlock, sleep supply switch and protection bytes.
// Assumes a plain register port with read data one cycle after the strobe.
`default_nettype none

// Behaviour
// [RL1] Writing 55 to the code protection register drops protection only after 300 ms.
// [RL2] Writing any other value to that register turns protection back on at once.
// [RL3] The status bit reads 1 while protection is off and 0 while it is on.
// [RL4] Writing 0x55 to the supply switch register sets the sleep supply-off flag.
// [RL5] With the flag set, flash supply removal is requested whenever in sleep.
// [RL6] The flag resets to 0, and with it clear the flash supply stays on always.
// [RL7] Reading the supply switch register gives the flag in bit 0, other bits zero.
module flash_protect_ctrl
	import flash_protect_pkg::*;
#(
	parameter int UNLOCK_CYCLES = UNLOCK_DELAY_CYCLES
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_q,
	input wire logic sleep_mode,
	output logic protect_en_q,
	output logic flash_supply_off_q,
	output logic [7:0] zone_permanent_protect_bits_q,
	output logic info_block0_protect_q,
	output logic info_block1_protect_q,
	output logic info_block0_permanent_protect_q,
	output logic info_block1_permanent_protect_q
);

	// ****************************************
	// Decode
	// ****************************************
	logic wr_code;
	logic wr_supply;
	logic wr_zone;
	logic wr_info;
	logic unlock_start;
	logic relock;
	logic unlock_expired_q;
	logic sleep_supply_off_flag_q;
	logic [7:0] info_q;
	logic [7:0] rdata_d;

	assign wr_code = reg_wr && (reg_addr == ADDR_CODE_PROTECT);
	assign wr_supply = reg_wr && (reg_addr == ADDR_SUPPLY_SWITCH);
	assign wr_zone = reg_wr && (reg_addr == ADDR_ZONE_PROTECT7);
	assign wr_info = reg_wr && (reg_addr == ADDR_INFO_PROTECT);
	assign unlock_start = wr_code && (reg_wdata == UNLOCK_VALUE);
	assign relock = wr_code && (reg_wdata != UNLOCK_VALUE);

	// ****************************************
	// Code protection unlock
	// ****************************************
	// Long hold-off rejects unlocks caused by supply or bus glitches
	unlock_delay_timer #(
		.DELAY_CYCLES(UNLOCK_CYCLES)
	) u_unlock_timer (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.start(unlock_start),
		.cancel(relock),
		.expired_q(unlock_expired_q)
	);

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			protect_en_q <= 1'b1;
		else if (wr_code)
			protect_en_q <= 1'b1; // RL1 RL2
		else if (unlock_expired_q)
			protect_en_q <= 1'b0; // RL1
	end

	// ****************************************
	// Sleep supply switch
	// ****************************************
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			sleep_supply_off_flag_q <= 1'b0; // RL6
		else if (wr_supply)
			sleep_supply_off_flag_q <= (reg_wdata == SUPPLY_OFF_VALUE); // RL4
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			flash_supply_off_q <= 1'b0;
		else
			flash_supply_off_q <= sleep_supply_off_flag_q && sleep_mode; // RL5 RL6
	end

	// ****************************************
	// Protection bytes
	// ****************************************
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			zone_permanent_protect_bits_q <= ZONE_PROTECT7_RESET;
		else if (wr_zone)
			zone_permanent_protect_bits_q <= reg_wdata;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			info_q <= INFO_PROTECT_RESET;
		else if (wr_info)
			info_q <= reg_wdata & INFO_PROTECT_MASK;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			info_block0_protect_q <= INFO_PROTECT_RESET[INFO_BLK0_PROT_BIT];
			info_block1_protect_q <= INFO_PROTECT_RESET[INFO_BLK1_PROT_BIT];
			info_block0_permanent_protect_q <= INFO_PROTECT_RESET[INFO_BLK0_PERM_BIT];
			info_block1_permanent_protect_q <= INFO_PROTECT_RESET[INFO_BLK1_PERM_BIT];
		end
		else if (wr_info)
		begin
			info_block0_protect_q <= reg_wdata[INFO_BLK0_PROT_BIT];
			info_block1_protect_q <= reg_wdata[INFO_BLK1_PROT_BIT];
			info_block0_permanent_protect_q <= reg_wdata[INFO_BLK0_PERM_BIT];
			info_block1_permanent_protect_q <= reg_wdata[INFO_BLK1_PERM_BIT];
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_comb
	begin
		rdata_d = 8'h00;
		if (reg_addr == ADDR_CODE_PROTECT)
			rdata_d[STATUS_BIT] = !protect_en_q; // RL3
		else if (reg_addr == ADDR_SUPPLY_SWITCH)
			rdata_d[SLEEP_FLAG_BIT] = sleep_supply_off_flag_q; // RL7
		else if (reg_addr == ADDR_ZONE_PROTECT7)
			rdata_d = zone_permanent_protect_bits_q;
		else if (reg_addr == ADDR_INFO_PROTECT)
			rdata_d = info_q;
	end

	// Data valid only in the cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			reg_rdata_q <= 8'h00;
		else if (reg_rd)
			reg_rdata_q <= rdata_d;
		else
			reg_rdata_q <= 8'h00;
	end

	// ****************************************
	// Checker helpers
	// ****************************************
	// Independent count of cycles since the unlock write, so the
	// timer length is judged against the parameter, not against itself
	logic unlock_pending_q;
	logic [31:0] since_unlock_q;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			unlock_pending_q <= 1'b0;
			since_unlock_q <= 32'h0;
		end
		else if (unlock_start)
		begin
			unlock_pending_q <= 1'b1;
			since_unlock_q <= 32'h0;
		end
		else if (relock || unlock_expired_q)
		begin
			unlock_pending_q <= 1'b0;
		end
		else if (unlock_pending_q)
		begin
			since_unlock_q <= since_unlock_q + 32'h1;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_unlock_delay_hold: assert property ( // RL1
		$fell(protect_en_q) |-> $past(unlock_expired_q) && !$past(wr_code))
		else $error("protection dropped without the unlock delay expiring");

	a_unlock_stays_on: assert property ( // RL1
		unlock_start |=> protect_en_q [*3])
		else $error("protection dropped too soon after unlock write");

	a_relock_immediate: assert property ( // RL2
		relock |=> protect_en_q ##1 protect_en_q)
		else $error("protection not restored after non-unlock write");

	a_status_readback: assert property ( // RL3
		reg_rd && reg_addr == ADDR_CODE_PROTECT |=>
		reg_rdata_q == {7'h00, !$past(protect_en_q)})
		else $error("status bit does not mirror protection state");

	a_flag_set: assert property ( // RL4
		wr_supply && reg_wdata == SUPPLY_OFF_VALUE |=> sleep_supply_off_flag_q)
		else $error("supply-off flag not set by 0x55 write");

	a_supply_off_sleep: assert property ( // RL5
		sleep_supply_off_flag_q && sleep_mode |=> flash_supply_off_q)
		else $error("flash supply not removed in sleep with flag set");

	a_supply_stays_on: assert property ( // RL6
		!sleep_supply_off_flag_q |=> !flash_supply_off_q)
		else $error("flash supply removed while flag is clear");

	a_flag_readback: assert property ( // RL7
		reg_rd && reg_addr == ADDR_SUPPLY_SWITCH |=>
		reg_rdata_q == {7'h00, $past(sleep_supply_off_flag_q)})
		else $error("supply switch readback wrong");

	a_release_after_expiry: assert property ( // RL1
		unlock_expired_q && !wr_code |=> !protect_en_q)
		else $error("protection kept on after the unlock delay expired");

	a_unlock_delay_length: assert property ( // RL1
		unlock_expired_q |-> unlock_pending_q && since_unlock_q == 32'(UNLOCK_CYCLES))
		else $error("unlock delay length differs from the configured count");

	a_protect_stays_off: assert property ( // RL1
		!protect_en_q && !wr_code |=> !protect_en_q)
		else $error("protection came back without a write");

	a_flag_clear: assert property ( // RL4
		wr_supply && reg_wdata != SUPPLY_OFF_VALUE |=> !sleep_supply_off_flag_q)
		else $error("supply-off flag not cleared by other write value");

	a_flag_hold: assert property ( // RL6
		!wr_supply |=> $stable(sleep_supply_off_flag_q))
		else $error("supply-off flag changed without a write");

	a_supply_awake: assert property ( // RL5
		!sleep_mode |=> !flash_supply_off_q)
		else $error("flash supply removed outside sleep");

	// Read data stand one cycle only, zero otherwise
	a_rdata_idle: assert property (
		!reg_rd |=> reg_rdata_q == 8'h00)
		else $error("read data not zero outside the read cycle");

	a_unmapped_read: assert property (
		reg_rd && reg_addr != ADDR_CODE_PROTECT && reg_addr != ADDR_SUPPLY_SWITCH &&
		reg_addr != ADDR_ZONE_PROTECT7 && reg_addr != ADDR_INFO_PROTECT |=>
		reg_rdata_q == 8'h00)
		else $error("unmapped read returned nonzero data");

	a_zone_write: assert property (
		wr_zone |=> zone_permanent_protect_bits_q == $past(reg_wdata))
		else $error("zone protect byte not loaded by write");

	a_zone_hold: assert property (
		!wr_zone |=> $stable(zone_permanent_protect_bits_q))
		else $error("zone protect byte changed without a write");

	a_zone_readback: assert property (
		reg_rd && reg_addr == ADDR_ZONE_PROTECT7 |=>
		reg_rdata_q == $past(zone_permanent_protect_bits_q))
		else $error("zone protect byte readback wrong");

	a_info_write: assert property (
		wr_info |=> info_q == ($past(reg_wdata) & INFO_PROTECT_MASK))
		else $error("info block protection not loaded by write");

	a_info_outputs: assert property (
		info_block0_protect_q == info_q[INFO_BLK0_PROT_BIT] &&
		info_block1_protect_q == info_q[INFO_BLK1_PROT_BIT] &&
		info_block0_permanent_protect_q == info_q[INFO_BLK0_PERM_BIT] &&
		info_block1_permanent_protect_q == info_q[INFO_BLK1_PERM_BIT])
		else $error("info block outputs disagree with stored bits");

	a_info_readback: assert property (
		reg_rd && reg_addr == ADDR_INFO_PROTECT |=>
		reg_rdata_q == $past(info_q))
		else $error("info block protection readback wrong");

	c_unlock_done: cover property (unlock_expired_q ##1 $fell(protect_en_q));
	c_flag_cleared: cover property ($fell(sleep_supply_off_flag_q));
	c_info_write: cover property (wr_info);
	c_relock_while_pending: cover property (unlock_start ##[1:20] relock);
	c_supply_off: cover property ($rose(flash_supply_off_q));

endmodule

`default_nettype wire

// >>> flash_protect_pkg.sv
// Constants shared by the flash protection and sleep supply block.
// Assumes a 200 MHz core clock and byte-wide registers on a 16-bit address.
`default_nettype none

package flash_protect_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [15:0] ADDR_SUPPLY_SWITCH = 16'ha015;
	localparam logic [15:0] ADDR_CODE_PROTECT = 16'ha027;
	localparam logic [15:0] ADDR_ZONE_PROTECT7 = 16'ha0c7;
	localparam logic [15:0] ADDR_INFO_PROTECT = 16'ha0c8;

	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam logic [7:0] UNLOCK_VALUE = 8'h55;
	localparam logic [7:0] SUPPLY_OFF_VALUE = 8'h55;
	localparam logic [7:0] ZONE_PROTECT7_RESET = 8'hff;
	localparam int INFO_BLK0_PROT_BIT = 0;
	localparam int INFO_BLK1_PROT_BIT = 1;
	localparam int INFO_BLK0_PERM_BIT = 4;
	localparam int INFO_BLK1_PERM_BIT = 5;
	localparam logic [7:0] INFO_PROTECT_MASK = 8'h33;
	localparam logic [7:0] INFO_PROTECT_RESET = 8'h30;
	localparam int STATUS_BIT = 0;
	localparam int SLEEP_FLAG_BIT = 0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_FREQ_KHZ = 200000;
	localparam int UNLOCK_DELAY_MS = 300;
	localparam int UNLOCK_DELAY_CYCLES = UNLOCK_DELAY_MS * CLK_FREQ_KHZ;

endpackage

`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the flash protection and sleep supply block.
// Assumes the register port answers reads one cycle after the strobe.
`default_nettype none

`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got %h want %h", $time, act, exp); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import flash_protect_pkg::*;

	// Short delay keeps the run brief; all timing checks derive from it
	localparam int UNLOCK_SIM = 20;
	localparam int CYCLE_LIMIT = 2000;

	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sleep_mode = 1'b0;
	logic [7:0] reg_rdata_q;
	logic protect_en_q;
	logic flash_supply_off_q;
	logic [7:0] zone_q;
	logic prot0_q, prot1_q, perm0_q, perm1_q;
	logic [7:0] rd_val;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;

	flash_protect_ctrl #(.UNLOCK_CYCLES(UNLOCK_SIM)) dut (
		.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .sleep_mode(sleep_mode),
		.protect_en_q(protect_en_q), .flash_supply_off_q(flash_supply_off_q),
		.zone_permanent_protect_bits_q(zone_q),
		.info_block0_protect_q(prot0_q), .info_block1_protect_q(prot1_q),
		.info_block0_permanent_protect_q(perm0_q),
		.info_block1_permanent_protect_q(perm1_q)
	);

	initial
	begin
		forever #2.5 core_clk = ~core_clk;
	end

	// ****************************************
	// Bus tasks and closing
	// ****************************************
	task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// Data is taken in the single cycle it stands
	task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata_q;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles >= CYCLE_LIMIT)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t run did not finish", $time);
			tally_and_finish();
		end
	end

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_reset_values();
		`CHK(protect_en_q, 1'b1)
		`CHK(flash_supply_off_q, 1'b0)
		`CHK(zone_q, 8'hff)
		`CHK({perm1_q, perm0_q, prot1_q, prot0_q}, 4'hc)
		reg_read(ADDR_SUPPLY_SWITCH, rd_val);
		`CHK(rd_val, 8'h00)
		reg_read(ADDR_CODE_PROTECT, rd_val);
		`CHK(rd_val, 8'h00)
		reg_read(ADDR_ZONE_PROTECT7, rd_val);
		`CHK(rd_val, 8'hff)
		reg_read(ADDR_INFO_PROTECT, rd_val);
		`CHK(rd_val, 8'h30)
	endtask

	task automatic test_unlock_delay();
		reg_write(ADDR_CODE_PROTECT, UNLOCK_VALUE);
		repeat (UNLOCK_SIM) @(posedge core_clk);
		#1;
		`CHK(protect_en_q, 1'b1)
		@(posedge core_clk);
		#1;
		`CHK(protect_en_q, 1'b0)
		reg_read(ADDR_CODE_PROTECT, rd_val);
		`CHK(rd_val, 8'h01)
		reg_write(ADDR_CODE_PROTECT, 8'h54);
		`CHK(protect_en_q, 1'b1)
		reg_read(ADDR_CODE_PROTECT, rd_val);
		`CHK(rd_val, 8'h00)
	endtask

	// Abort in mid-delay must cancel the pending release
	task automatic test_unlock_abort();
		reg_write(ADDR_CODE_PROTECT, UNLOCK_VALUE);
		repeat (UNLOCK_SIM / 2) @(posedge core_clk);
		reg_write(ADDR_CODE_PROTECT, 8'h00);
		repeat (UNLOCK_SIM + 4) @(posedge core_clk);
		#1;
		`CHK(protect_en_q, 1'b1)
	endtask

	task automatic test_sleep_supply();
		@(posedge core_clk);
		sleep_mode <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		`CHK(flash_supply_off_q, 1'b0)
		reg_write(ADDR_SUPPLY_SWITCH, SUPPLY_OFF_VALUE);
		reg_read(ADDR_SUPPLY_SWITCH, rd_val);
		`CHK(rd_val, 8'h01)
		`CHK(flash_supply_off_q, 1'b1)
		@(posedge core_clk);
		sleep_mode <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		`CHK(flash_supply_off_q, 1'b0)
		reg_write(ADDR_SUPPLY_SWITCH, 8'hff);
		reg_read(ADDR_SUPPLY_SWITCH, rd_val);
		`CHK(rd_val, 8'h00)
	endtask

	task automatic test_protect_bytes();
		reg_write(ADDR_ZONE_PROTECT7, 8'h5a);
		reg_write(ADDR_INFO_PROTECT, 8'hff);
		`CHK(zone_q, 8'h5a)
		`CHK({perm1_q, perm0_q, prot1_q, prot0_q}, 4'hf)
		reg_read(ADDR_INFO_PROTECT, rd_val);
		`CHK(rd_val, 8'h33)
		@(posedge core_clk);
		#1;
		`CHK(reg_rdata_q, 8'h00)
		reg_read(ADDR_ZONE_PROTECT7, rd_val);
		`CHK(rd_val, 8'h5a)
		reg_write(16'ha016, 8'h55);
		reg_read(16'ha016, rd_val);
		`CHK(rd_val, 8'h00)
		reg_read(ADDR_SUPPLY_SWITCH, rd_val);
		`CHK(rd_val, 8'h00)
	endtask

	initial
	begin
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		#1;
		test_reset_values();
		test_unlock_delay();
		test_unlock_abort();
		test_sleep_supply();
		test_protect_bytes();
		tally_and_finish();
	end
endmodule

`default_nettype wire

// >>> unlock_delay_timer.sv
// Down counter that signals when the unlock delay has run out.
// Assumes start and cancel are one-cycle pulses, never both at once.
`default_nettype none

module unlock_delay_timer
	import flash_protect_pkg::*;
#(
	parameter int DELAY_CYCLES = UNLOCK_DELAY_CYCLES
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic cancel,
	output logic expired_q
);

	logic [31:0] count_q;
	logic running_q;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count_q <= 32'h0;
			running_q <= 1'b0;
			expired_q <= 1'b0;
		end
		else
		begin
			expired_q <= 1'b0;
			if (start)
			begin
				count_q <= 32'(DELAY_CYCLES - 1);
				running_q <= 1'b1;
			end
			else if (cancel)
			begin
				running_q <= 1'b0;
			end
			else if (running_q)
			begin
				if (count_q == 32'h0)
				begin
					running_q <= 1'b0;
					expired_q <= 1'b1;
				end
				else
				begin
					count_q <= count_q - 32'h1;
				end
			end
		end
	end

endmodule

`default_nettype wire
